// [design/sp1_serial_port.sv]
`timescale 1ns/1ps
// Function
// - Async frames: start, 8/9 data, stop
// - Mode bits pick the bit rate
// - Mode 1 multiprocessor: need valid stop
// - Modes 2/3 multiprocessor: ninth zero, no flag
// - Peripheral clock halts during idle
// - Enable bit gates reception; mode 0 starts
// - Ninth transmitted bit from control bit
// - Ninth received bit or stop captured
// - Mode 0 transmit done after eighth bit
// - Async transmit done after last data bit
// - Mode 0 receive done after eighth bit
// - Mode 1 receive done after stop sample
// - Modes 2/3 done after ninth sample
// - Buffer address: write transmit, read receive
// - Control register resets to zero
module sp1_serial_port #(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Special function register bus
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // Timing sources
  input  wire logic       idle_mode,
  input  wire logic       timer1_ovf,
  input  wire logic       rate_double_bit,
  // Serial pins
  input  wire logic       data_pin_in,
  output logic            data_pin_out,
  output logic            data_pin_oe_n,
  output logic            txd_out,
  // Flags toward the core
  output logic            transmit_done_flag,
  output logic            receive_done_flag
);

  if (DATA_W != 8) begin : g_width_check
    $error("sp1_serial_port serves 8-bit data only");
  end

  // Control and buffers
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] rxbuf_r;
  logic [7:0] rxbuf_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  // Transmitter
  sp1_pkg::sp1_tx_state_t tx_state_r;
  sp1_pkg::sp1_tx_state_t tx_state_nxt;
  logic [8:0] tx_sh_r;
  logic [8:0] tx_sh_nxt;
  logic [3:0] tx_cnt_r;
  logic [3:0] tx_cnt_nxt;
  logic [3:0] tx_ph_r;
  logic [3:0] tx_ph_nxt;
  logic       tx_done_set;
  logic       tx_line;
  // Receiver
  sp1_pkg::sp1_rx_state_t rx_state_r;
  sp1_pkg::sp1_rx_state_t rx_state_nxt;
  logic [8:0] rx_sh_r;
  logic [8:0] rx_sh_nxt;
  logic [3:0] rx_cnt_r;
  logic [3:0] rx_cnt_nxt;
  logic [3:0] rx_ph_r;
  logic [3:0] rx_ph_nxt;
  logic       rx_done_set;
  logic       rx_load_b8;
  logic       rx_b8;
  logic [7:0] rx_byte;
  logic [8:0] rx_shifted;
  // Pin synchroniser and pins
  logic       sync1_r;
  logic       sync2_r;
  logic       sync3_r;
  logic       lvl_r;
  logic       lvl_nxt;
  logic       lvl_d_r;
  logic       pin_out_r;
  logic       pin_out_nxt;
  logic       pin_oe_n_r;
  logic       pin_oe_n_nxt;
  logic       txd_r;
  logic       txd_nxt;
  // Decodes
  logic [1:0] mode;
  logic       mode0;
  logic       mp_sel;
  logic       ren;
  logic [3:0] last_bit;
  logic       tick;
  logic       pclk_en;
  logic       wr_ctrl;
  logic       wr_buf;
  logic       fall;

  assign mode     = {ctrl_r[sp1_pkg::SP1_MODE_HI], ctrl_r[sp1_pkg::SP1_MODE_LO]};
  assign mode0    = (mode == sp1_pkg::SP1_MODE_SYNC);
  assign mp_sel   = ctrl_r[sp1_pkg::SP1_MP];
  assign ren      = ctrl_r[sp1_pkg::SP1_REN];
  assign last_bit = (mode == sp1_pkg::SP1_MODE_ASY8) ? sp1_pkg::SP1_LAST_BIT8 : sp1_pkg::SP1_LAST_BIT9;
  assign wr_ctrl  = sfr_wr && (sfr_addr == sp1_pkg::SP1_CTRL_ADDR);
  assign wr_buf   = sfr_wr && (sfr_addr == sp1_pkg::SP1_BUF_ADDR);
  assign pclk_en  = !idle_mode;
  assign fall     = lvl_d_r && !lvl_r;

  sp1_rate_gen u_rate (
    .clock      (clock),
    .rst        (rst),
    .pclk_en    (pclk_en),
    .timer1_ovf (timer1_ovf),
    .mode       (mode),
    .mp_sel     (mp_sel),
    .dbl        (rate_double_bit),
    .tick       (tick)
  );

  // Control, flags and read data
  always_comb begin
    ctrl_nxt  = ctrl_r;
    rxbuf_nxt = rxbuf_r;
    rdata_nxt = 8'h00;
    if (wr_ctrl) begin
      ctrl_nxt = sfr_wdata;
    end
    // Hardware set wins over a same-cycle software clear
    if (tx_done_set) begin
      ctrl_nxt[sp1_pkg::SP1_TI] = 1'b1;
    end
    if (rx_done_set) begin
      ctrl_nxt[sp1_pkg::SP1_RI] = 1'b1;
      rxbuf_nxt                 = rx_byte;
      if (rx_load_b8) begin
        ctrl_nxt[sp1_pkg::SP1_RB8] = rx_b8;
      end
    end
    if (sfr_rd) begin
      if (sfr_addr == sp1_pkg::SP1_CTRL_ADDR) begin
        rdata_nxt = ctrl_r;
      end else if (sfr_addr == sp1_pkg::SP1_BUF_ADDR) begin
        rdata_nxt = rxbuf_r;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_r  <= sp1_pkg::SP1_CTRL_RESET;
      rxbuf_r <= sp1_pkg::SP1_BUF_RESET;
      rdata_r <= 8'h00;
    end else begin
      ctrl_r  <= ctrl_nxt;
      rxbuf_r <= rxbuf_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Transmitter
  always_comb begin
    tx_state_nxt = tx_state_r;
    tx_sh_nxt    = tx_sh_r;
    tx_cnt_nxt   = tx_cnt_r;
    tx_ph_nxt    = tx_ph_r;
    tx_done_set  = 1'b0;
    tx_line      = 1'b1;
    unique case (tx_state_r)
      sp1_pkg::SP1_TX_IDLE: begin
        // Mode 0 shares the data pin, so a write during reception is dropped
        if (wr_buf && !(mode0 && rx_state_r != sp1_pkg::SP1_RX_IDLE)) begin
          tx_sh_nxt    = {ctrl_r[sp1_pkg::SP1_TB8], sfr_wdata};
          tx_cnt_nxt   = 4'h0;
          tx_ph_nxt    = 4'h0;
          tx_state_nxt = sp1_pkg::SP1_TX_START;
        end
      end
      sp1_pkg::SP1_TX_START: begin
        tx_line = 1'b0;
        if (tick) begin
          tx_ph_nxt = tx_ph_r + 4'h1;
          // Mode 0 aligns to a tick so the first clock half is full length
          if (mode0) begin
            tx_ph_nxt    = 4'h0;
            tx_state_nxt = sp1_pkg::SP1_TX_DATA;
          end else if (tx_ph_r == sp1_pkg::SP1_PH_LAST) begin
            tx_state_nxt = sp1_pkg::SP1_TX_DATA;
          end
        end
      end
      sp1_pkg::SP1_TX_DATA: begin
        tx_line = tx_sh_r[0];
        if (tick) begin
          tx_ph_nxt = tx_ph_r + 4'h1;
          if (mode0 ? tx_ph_r[0] : (tx_ph_r == sp1_pkg::SP1_PH_LAST)) begin
            tx_ph_nxt  = 4'h0;
            tx_sh_nxt  = {1'b1, tx_sh_r[8:1]};
            tx_cnt_nxt = tx_cnt_r + 4'h1;
            if (mode0 && tx_cnt_r == sp1_pkg::SP1_LAST_BIT8) begin
              tx_done_set  = 1'b1;
              tx_state_nxt = sp1_pkg::SP1_TX_IDLE;
            end else if (!mode0 && tx_cnt_r == last_bit) begin
              tx_done_set  = 1'b1;
              tx_state_nxt = sp1_pkg::SP1_TX_STOP;
            end
          end
        end
      end
      sp1_pkg::SP1_TX_STOP: begin
        tx_line = 1'b1;
        if (tick) begin
          tx_ph_nxt = tx_ph_r + 4'h1;
          if (tx_ph_r == sp1_pkg::SP1_PH_LAST) begin
            tx_state_nxt = sp1_pkg::SP1_TX_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tx_state_r <= sp1_pkg::SP1_TX_IDLE;
      tx_sh_r    <= 9'h1FF;
      tx_cnt_r   <= 4'h0;
      tx_ph_r    <= 4'h0;
    end else begin
      tx_state_r <= tx_state_nxt;
      tx_sh_r    <= tx_sh_nxt;
      tx_cnt_r   <= tx_cnt_nxt;
      tx_ph_r    <= tx_ph_nxt;
    end
  end

  // Receiver
  always_comb begin
    rx_state_nxt = rx_state_r;
    rx_sh_nxt    = rx_sh_r;
    rx_cnt_nxt   = rx_cnt_r;
    rx_ph_nxt    = rx_ph_r;
    rx_done_set  = 1'b0;
    rx_load_b8   = 1'b0;
    rx_b8        = lvl_r;
    rx_shifted   = {lvl_r, rx_sh_r[8:1]};
    rx_byte      = rx_shifted[8:1];
    unique case (rx_state_r)
      sp1_pkg::SP1_RX_IDLE: begin
        rx_ph_nxt  = 4'h0;
        rx_cnt_nxt = 4'h0;
        if (mode0) begin
          if (ren && !ctrl_r[sp1_pkg::SP1_RI] && tx_state_r == sp1_pkg::SP1_TX_IDLE) begin
            rx_state_nxt = sp1_pkg::SP1_RX_START;
          end
        end else if (ren && fall) begin
          rx_state_nxt = sp1_pkg::SP1_RX_START;
        end
      end
      sp1_pkg::SP1_RX_START: begin
        if (tick) begin
          rx_ph_nxt = rx_ph_r + 4'h1;
          // A start bit high at mid-bit was a glitch
          if (mode0) begin
            rx_ph_nxt    = 4'h0;
            rx_state_nxt = sp1_pkg::SP1_RX_DATA;
          end else if (rx_ph_r == sp1_pkg::SP1_PH_SAMPLE && lvl_r) begin
            rx_state_nxt = sp1_pkg::SP1_RX_IDLE;
          end else if (rx_ph_r == sp1_pkg::SP1_PH_LAST) begin
            rx_state_nxt = sp1_pkg::SP1_RX_DATA;
          end
        end
      end
      sp1_pkg::SP1_RX_DATA: begin
        if (tick) begin
          rx_ph_nxt = rx_ph_r + 4'h1;
          if (mode0) begin
            // Sample at the end of the clock-high half
            if (rx_ph_r[0]) begin
              rx_ph_nxt  = 4'h0;
              rx_sh_nxt  = rx_shifted;
              rx_cnt_nxt = rx_cnt_r + 4'h1;
              if (rx_cnt_r == sp1_pkg::SP1_LAST_BIT8) begin
                rx_done_set  = 1'b1;
                rx_state_nxt = sp1_pkg::SP1_RX_IDLE;
              end
            end
          end else if (rx_ph_r == sp1_pkg::SP1_PH_SAMPLE) begin
            rx_sh_nxt  = rx_shifted;
            rx_cnt_nxt = rx_cnt_r + 4'h1;
            if (rx_cnt_r == sp1_pkg::SP1_LAST_BIT9 && mode != sp1_pkg::SP1_MODE_ASY8) begin
              rx_byte     = rx_shifted[7:0];
              rx_load_b8  = 1'b1;
              rx_done_set = !ctrl_r[sp1_pkg::SP1_RI] && (!mp_sel || lvl_r);
            end
          end else if (rx_ph_r == sp1_pkg::SP1_PH_LAST && rx_cnt_r > last_bit) begin
            rx_state_nxt = sp1_pkg::SP1_RX_STOP;
          end
        end
      end
      sp1_pkg::SP1_RX_STOP: begin
        rx_byte = rx_sh_r[8:1];
        if (tick) begin
          rx_ph_nxt = rx_ph_r + 4'h1;
          if (rx_ph_r == sp1_pkg::SP1_PH_SAMPLE) begin
            rx_state_nxt = sp1_pkg::SP1_RX_IDLE;
            if (mode == sp1_pkg::SP1_MODE_ASY8) begin
              rx_load_b8  = 1'b1;
              rx_done_set = !ctrl_r[sp1_pkg::SP1_RI] && (!mp_sel || lvl_r);
            end
          end
        end
      end
    endcase
    if (!ren) begin
      rx_state_nxt = sp1_pkg::SP1_RX_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rx_state_r <= sp1_pkg::SP1_RX_IDLE;
      rx_sh_r    <= 9'h000;
      rx_cnt_r   <= 4'h0;
      rx_ph_r    <= 4'h0;
    end else begin
      rx_state_r <= rx_state_nxt;
      rx_sh_r    <= rx_sh_nxt;
      rx_cnt_r   <= rx_cnt_nxt;
      rx_ph_r    <= rx_ph_nxt;
    end
  end

  // Pin input: three stages, level moves once stages two and three agree
  always_comb begin
    lvl_nxt = (sync2_r == sync3_r) ? sync3_r : lvl_r;
  end

  // Pin outputs; mode 0 drives the shift clock on txd
  always_comb begin
    pin_out_nxt  = 1'b1;
    pin_oe_n_nxt = 1'b1;
    txd_nxt      = tx_line;
    if (mode0) begin
      txd_nxt = 1'b1;
      if (tx_state_r == sp1_pkg::SP1_TX_DATA) begin
        pin_out_nxt  = tx_sh_r[0];
        pin_oe_n_nxt = 1'b0;
        txd_nxt      = tx_ph_r[0];
      end else if (rx_state_r == sp1_pkg::SP1_RX_DATA) begin
        txd_nxt = rx_ph_r[0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_r    <= 1'b1;
      sync2_r    <= 1'b1;
      sync3_r    <= 1'b1;
      lvl_r      <= 1'b1;
      lvl_d_r    <= 1'b1;
      pin_out_r  <= 1'b1;
      pin_oe_n_r <= 1'b1;
      txd_r      <= 1'b1;
    end else begin
      sync1_r    <= data_pin_in;
      sync2_r    <= sync1_r;
      sync3_r    <= sync2_r;
      lvl_r      <= lvl_nxt;
      lvl_d_r    <= lvl_r;
      pin_out_r  <= pin_out_nxt;
      pin_oe_n_r <= pin_oe_n_nxt;
      txd_r      <= txd_nxt;
    end
  end

  assign sfr_rdata          = rdata_r;
  assign data_pin_out       = pin_out_r;
  assign data_pin_oe_n      = pin_oe_n_r;
  assign txd_out            = txd_r;
  assign transmit_done_flag = ctrl_r[sp1_pkg::SP1_TI];
  assign receive_done_flag  = ctrl_r[sp1_pkg::SP1_RI];

endmodule : sp1_serial_port

// [design/sp1_pkg.sv]
package sp1_pkg;

  // Register map
  localparam logic [7:0] SP1_CTRL_ADDR  = 8'hC0;
  localparam logic [7:0] SP1_BUF_ADDR   = 8'hC1;
  localparam logic [7:0] SP1_CTRL_RESET = 8'h00;
  localparam logic [7:0] SP1_BUF_RESET  = 8'h00;

  // Control register field positions
  localparam int SP1_MODE_HI = 7;
  localparam int SP1_MODE_LO = 6;
  localparam int SP1_MP      = 5;
  localparam int SP1_REN     = 4;
  localparam int SP1_TB8     = 3;
  localparam int SP1_RB8     = 2;
  localparam int SP1_TI      = 1;
  localparam int SP1_RI      = 0;

  // Mode encodings {hi, lo}
  localparam logic [1:0] SP1_MODE_SYNC  = 2'h0;
  localparam logic [1:0] SP1_MODE_ASY8  = 2'h1;
  localparam logic [1:0] SP1_MODE_FIX9  = 2'h2;
  localparam logic [1:0] SP1_MODE_VAR9  = 2'h3;

  // Bit periods in peripheral clocks; the divider ticks at half bit (sync) or 1/16 bit (async)
  localparam int SP1_M0_BIT_PCLK      = 12;
  localparam int SP1_M0_FAST_BIT_PCLK = 4;
  localparam int SP1_M2_BIT_PCLK      = 64;
  localparam int SP1_M2_DBL_BIT_PCLK  = 32;
  localparam int SP1_OVERSAMPLE       = 16;
  localparam logic [5:0] SP1_DIV_M0      = 6'(SP1_M0_BIT_PCLK / 2);
  localparam logic [5:0] SP1_DIV_M0_FAST = 6'(SP1_M0_FAST_BIT_PCLK / 2);
  localparam logic [5:0] SP1_DIV_M2      = 6'(SP1_M2_BIT_PCLK / SP1_OVERSAMPLE);
  localparam logic [5:0] SP1_DIV_M2_DBL  = 6'(SP1_M2_DBL_BIT_PCLK / SP1_OVERSAMPLE);
  localparam logic [5:0] SP1_DIV_T1      = 6'h02;
  localparam logic [5:0] SP1_DIV_T1_DBL  = 6'h01;

  // Phase within one async bit
  localparam logic [3:0] SP1_PH_LAST   = 4'(SP1_OVERSAMPLE - 1);
  localparam logic [3:0] SP1_PH_SAMPLE = 4'(SP1_OVERSAMPLE / 2 - 1);

  // Index of the last data bit
  localparam logic [3:0] SP1_LAST_BIT8 = 4'h7;
  localparam logic [3:0] SP1_LAST_BIT9 = 4'h8;

  typedef enum logic [1:0] {
    SP1_TX_IDLE  = 2'h0,
    SP1_TX_START = 2'h1,
    SP1_TX_DATA  = 2'h3,
    SP1_TX_STOP  = 2'h2
  } sp1_tx_state_t;

  typedef enum logic [1:0] {
    SP1_RX_IDLE  = 2'h0,
    SP1_RX_START = 2'h1,
    SP1_RX_DATA  = 2'h3,
    SP1_RX_STOP  = 2'h2
  } sp1_rx_state_t;

endpackage : sp1_pkg

// [design/sp1_rate_gen.sv]
`timescale 1ns/1ps
module sp1_rate_gen (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Rate selection
  input  wire logic       pclk_en,
  input  wire logic       timer1_ovf,
  input  wire logic [1:0] mode,
  input  wire logic       mp_sel,
  input  wire logic       dbl,
  // Tick: half bit in sync mode, one sixteenth bit otherwise
  output logic            tick
);

  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic       tick_r;
  logic       tick_nxt;
  logic [5:0] div;
  logic       ev;

  always_comb begin
    div = sp1_pkg::SP1_DIV_T1;
    ev  = timer1_ovf;
    unique case (mode)
      sp1_pkg::SP1_MODE_SYNC: begin
        div = mp_sel ? sp1_pkg::SP1_DIV_M0_FAST : sp1_pkg::SP1_DIV_M0;
        ev  = pclk_en;
      end
      sp1_pkg::SP1_MODE_FIX9: begin
        div = dbl ? sp1_pkg::SP1_DIV_M2_DBL : sp1_pkg::SP1_DIV_M2;
        ev  = pclk_en;
      end
      sp1_pkg::SP1_MODE_ASY8, sp1_pkg::SP1_MODE_VAR9: begin
        div = dbl ? sp1_pkg::SP1_DIV_T1_DBL : sp1_pkg::SP1_DIV_T1;
        ev  = timer1_ovf;
      end
    endcase
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (ev) begin
      // Counter may sit past div after a rate change; wrap rather than stall
      if (cnt_r >= div - 6'h01) begin
        cnt_nxt  = 6'h00;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 6'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_r  <= 6'h00;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule : sp1_rate_gen

// [bench/sp1_chk.sv]
`timescale 1ns/1ps
module sp1_chk (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // Register bus
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // Pins and flags
  input wire logic       idle_mode,
  input wire logic       data_pin_in,
  input wire logic       data_pin_oe_n,
  input wire logic       txd_out,
  input wire logic       transmit_done_flag,
  input wire logic       receive_done_flag
);
  logic [7:0] ctl_r;
  logic [7:0] low_r;
  logic [7:0] oe_r;
  logic       m0;
  logic       map;
  assign m0  = ctl_r[7:6] == sp1_pkg::SP1_MODE_SYNC;
  assign map = sfr_addr == sp1_pkg::SP1_CTRL_ADDR || sfr_addr == sp1_pkg::SP1_BUF_ADDR;
  // Software bits only; hardware flag sets are not mirrored
  always_ff @(posedge clock) begin
    if (rst) begin
      ctl_r <= 8'h00;
      low_r <= 8'h00;
      oe_r  <= 8'h00;
    end else begin
      if (sfr_wr && sfr_addr == sp1_pkg::SP1_CTRL_ADDR) ctl_r <= sfr_wdata;
      low_r <= txd_out ? 8'h00 : low_r + 8'h01;
      oe_r  <= data_pin_oe_n ? 8'h00 : oe_r + 8'h01;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  rst_vals_a: assert property ($fell(rst) |-> txd_out && data_pin_oe_n && sfr_rdata == 8'h00
    && !transmit_done_flag && !receive_done_flag) else $error("outputs not at rest after reset");
  unmap_rd_a: assert property (sfr_rd && !map |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  rd_idle_a: assert property (!sfr_rd |=> sfr_rdata == 8'h00) else $error("read data without read");
  idle_hold_a: assert property (idle_mode && $past(idle_mode) && $past(idle_mode, 2)
    && ctl_r[7:6] == sp1_pkg::SP1_MODE_FIX9 |-> $stable(txd_out)) else $error("line moved in idle");
  clk_half_a: assert property ($rose(txd_out) && m0 |-> low_r == (ctl_r[5] ? 8'h02 : 8'h06))
    else $error("shift clock low half wrong");
  oe_len_a: assert property ($rose(data_pin_oe_n) && m0 |-> oe_r == (ctl_r[5] ? 8'h20 : 8'h60))
    else $error("sync drive length wrong");
  m0_done_a: assert property ($rose(data_pin_oe_n) && m0 |-> ##[0:2] transmit_done_flag)
    else $error("sync transmit done missing");
  tx_stop_a: assert property ($rose(transmit_done_flag) && !m0 && !$past(sfr_wr)
    |-> ##2 txd_out [*8]) else $error("stop bit not after done");
  ninth_tx_a: assert property ($rose(transmit_done_flag) && ctl_r[7] && !$past(sfr_wr)
    |-> $past(txd_out, 3) == ctl_r[3]) else $error("ninth bit wrong");
  rx_enable_a: assert property ($rose(receive_done_flag) && !$past(sfr_wr) |-> ctl_r[4])
    else $error("receive done while disabled");
  rx_mp_a: assert property ($rose(receive_done_flag) && ctl_r[5] && !m0
    |-> $past(data_pin_in, 5)) else $error("multiprocessor frame accepted");
  cover property ($rose(transmit_done_flag));
  cover property ($rose(receive_done_flag));
  cover property ($fell(data_pin_oe_n));
endmodule : sp1_chk
bind sp1_serial_port sp1_chk chk (
  .clock, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .idle_mode,
  .data_pin_in, .data_pin_oe_n, .txd_out, .transmit_done_flag, .receive_done_flag
);

// [bench/sp1_remote.sv]
`timescale 1ns/1ps
module sp1_remote (
  // Clock
  input  wire logic clock,
  // Lines from the port
  input  wire logic txd_out,
  input  wire logic data_pin_oe_n,
  input  wire logic data_pin_out,
  // Line toward the port
  output logic      line
);
  int          per = 64;
  int          nb = 11;
  int          k = 0;
  int          n = 0;
  bit          sync = 1'b0;
  logic [7:0]  m0 = 8'h00;
  logic [7:0]  m0s = 8'h00;
  logic [10:0] got;
  logic [10:0] q[$];
  initial line = 1'b1;
  // Async catcher, one mid-bit sample per bit
  always @(negedge txd_out) begin
    if (!sync) begin
      got = '0;
      repeat (per / 2) @(posedge clock);
      for (int i = 0; i < nb; i++) begin
        got[i] = txd_out;
        repeat (per) @(posedge clock);
      end
      q.push_back(got);
    end
  end
  // Sync catcher: data settled at the rising shift clock
  always @(posedge txd_out) begin
    if (sync && !data_pin_oe_n) begin
      m0 = {data_pin_out, m0[7:1]};
      k++;
      if (k == 8) begin
        q.push_back({3'h0, m0});
        k = 0;
      end
    end
  end
  // Sync source: step after the sample point, never inside it
  always @(negedge txd_out) begin
    if (sync && data_pin_oe_n) begin
      n++;
      line <= m0s[(n - 1) % 8];
    end
  end
  // Line rests at the marking level between frames
  task automatic send(input logic [10:0] f, input int cnt);
    for (int i = 0; i < cnt; i++) begin
      line <= f[i];
      repeat (per) @(posedge clock);
    end
    line <= 1'b1;
  endtask : send
endmodule : sp1_remote

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  sfr_addr = 8'h00;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [7:0]  sfr_rdata;
  logic        idle_mode = 1'b0;
  logic        timer1_ovf = 1'b0;
  logic        rate_double_bit = 1'b0;
  logic        data_pin_in;
  logic        data_pin_out;
  logic        data_pin_oe_n;
  logic        txd_out;
  logic        transmit_done_flag;
  logic        receive_done_flag;
  logic        rd_p = 1'b0;
  logic [7:0]  rd_q[$];
  logic [10:0] fr_q[$];
  int          num_errors = 0;
  int          n_tests = 0;
  int          seed = 50;
  logic [7:0]  d;
  logic [7:0]  last = 8'h00;
  logic [7:0]  cfg[7] = '{8'h50, 8'h70, 8'h40, 8'h70, 8'hF0, 8'hF0, 8'hD0};
  logic        fin[7] = '{1, 0, 1, 1, 0, 1, 0};
  logic        ok[7] = '{1, 0, 0, 1, 0, 1, 1};
  sp1_serial_port #(.DATA_W(8)) dut (
    .clock, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .idle_mode, .timer1_ovf,
    .rate_double_bit, .data_pin_in, .data_pin_out, .data_pin_oe_n, .txd_out, .transmit_done_flag,
    .receive_done_flag
  );
  sp1_remote rem (.clock, .txd_out, .data_pin_oe_n, .data_pin_out, .line(data_pin_in));
  always #10 clock = ~clock;
  // Overflow every other cycle gives 64 cycles a bit
  always @(posedge clock) timer1_ovf <= ~timer1_ovf;
  always @(posedge clock) rd_p <= sfr_rd;
  task automatic print_verdict();
    $display("errors %0d, comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  // Read data is settled by the falling edge after the read
  always @(negedge clock) begin
    if (rd_p) check(sfr_rdata, rd_q.pop_front());
    if (rem.q.size() > 0) check(rem.q.pop_front(), fr_q.pop_front());
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    sfr_addr <= a;
    sfr_wdata <= v;
    sfr_wr <= 1'b1;
    @(posedge clock);
    sfr_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    rd_q.push_back(exp);
    @(posedge clock);
    sfr_rd <= 1'b0;
  endtask : rd
  task automatic wait_for(input int w, input int lim);
    int i;
    i = 0;
    while (i < lim && !(w == 0 ? transmit_done_flag === 1'b1 :
                        w == 1 ? receive_done_flag === 1'b1 : fr_q.size() == 0)) begin
      @(posedge clock);
      i++;
    end
    if (i == lim) begin
      num_errors++;
      print_verdict();
    end
  endtask : wait_for
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rd(8'hC0, 8'h00);
    wr(8'h3A, 8'hFF);
    rd(8'h3A, 8'h00);
    wr(8'hC0, 8'hEC);
    rd(8'hC0, 8'hEC);
    // Mode 2 sends at both rates; the second write hits a busy transmitter
    for (int i = 0; i < 2; i++) begin
      d = $random(seed);
      rem.per = i ? 32 : 64;
      rem.nb = 11;
      rate_double_bit <= i[0];
      wr(8'hC0, {4'h8, i[0], 3'h0});
      idle_mode <= 1'b1;
      repeat (20) @(posedge clock);
      idle_mode <= 1'b0;
      fr_q.push_back({1'b1, i[0], d, 1'b0});
      wr(8'hC1, d);
      wr(8'hC1, ~d);
      wait_for(0, 1000);
      rd(8'hC0, {4'h8, i[0], 3'h2});
      wait_for(2, 1000);
    end
    rate_double_bit <= 1'b0;
    rem.per = 64;
    // Receive table: modes 1 and 3, multiprocessor and enable cases
    for (int j = 0; j < 7; j++) begin
      d = $random(seed);
      wr(8'hC0, cfg[j]);
      rem.send({1'b1, fin[j], d, 1'b0}, cfg[j][7] ? 11 : 10);
      check(receive_done_flag, ok[j]);
      if (ok[j]) last = d;
      rd(8'hC0, cfg[j] | {5'h0, cfg[j][4] & fin[j], 1'b0, ok[j]});
      rd(8'hC1, last);
    end
    // Mode 0 sends at both shift rates
    rem.sync = 1'b1;
    for (int m = 0; m < 2; m++) begin
      d = $random(seed);
      rem.k = 0;
      wr(8'hC0, {2'h0, m[0], 5'h0});
      fr_q.push_back({3'h0, d});
      wr(8'hC1, d);
      wait_for(0, 300);
      wait_for(2, 50);
      rd(8'hC0, {2'h0, m[0], 5'h2});
    end
    d = $random(seed);
    rem.m0s = d;
    rem.n = 0;
    rem.line <= d[0];
    wr(8'hC0, 8'h10);
    wait_for(1, 300);
    rd(8'hC0, 8'h11);
    rd(8'hC1, d);
    wr(8'hC0, 8'h00);
    repeat (20) @(posedge clock);
    print_verdict();
  end
endmodule : testbench
